// File: verilog/pc_stack_pkg.sv
// constants and types of the program-flow and indirect addressing unit
//
// Overview of operation
// (RQ1) Program counter is 15 bits; low byte is a register; all reset clear it.
// (RQ2) Writing the low byte also loads the high bits from the high latch.
// (RQ3) Direct call: low byte and bits 2:0 from operand, bits 6:3 from latch.
// (RQ4) Indirect call: low byte from working register, high bits from latch.
// (RQ5) Register branch: counter becomes counter plus one plus unsigned working.
// (RQ6) Operand branch: counter becomes counter plus one plus signed operand.
// (RQ7) Return stack holds 16 entries of 15 bits, outside program and data space.
// (RQ8) Calls and interrupts push, returns pop; the high latch stays untouched.
// (RQ9) With fault reset off, the stack wraps and overwrites oldest entries.
// (RQ10) Overflow and underflow always set their flags.
// (RQ11) Stack pointer register positions the top-of-stack byte registers.
// (RQ12) Stack pointer is 5 bits so faults beyond 16 entries show.
// (RQ13) Push increments pointer then writes; pop reads then decrements.
// (RQ14) Empty stack is pointer 0x1F; first push gives 0x00.
// (RQ15) With fault reset on, overflow or underflow resets and sets the flag.
// (RQ16) Indirect data access goes to the location named by its pointer pair.
// (RQ17) Pointer naming an indirect data register reads zero, write dropped.
// (RQ18) Pointer 0x000 to 0xFFF maps straight onto absolute data addresses.
// (RQ19) Pointer 0x2000 to 0x29AF maps onto 80-byte blocks of each bank.
// (RQ20) Unmapped linear locations read zero; common bytes are not included.
// (RQ21) Pointer top bit set reads program flash low byte, no write, one extra.
// (RQ22) Configuration words sit at program addresses 8007h and 8008h.
// (RQ23) Stack fault reset option is bit 9 of the second configuration word.
// (RQ24) Otherwise the counter steps by one per instruction.
package pc_stack_pkg;

  localparam int unsigned PC_W      = 15;
  localparam int unsigned STK_DEPTH = 16;
  localparam int unsigned SP_W      = 5;
  localparam logic [4:0]  SP_EMPTY  = 5'h1F;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PC_LOW    = 16'h0000;
  localparam logic [15:0] IDX_PC_LATCH  = 16'h0001;
  localparam logic [15:0] IDX_STACK_PTR = 16'h0002;
  localparam logic [15:0] IDX_TOS_LOW   = 16'h0003;
  localparam logic [15:0] IDX_TOS_HIGH  = 16'h0004;
  localparam logic [15:0] IDX_PTR0_LOW  = 16'h0005;
  localparam logic [15:0] IDX_PTR0_HIGH = 16'h0006;
  localparam logic [15:0] IDX_PTR1_LOW  = 16'h0007;
  localparam logic [15:0] IDX_PTR1_HIGH = 16'h0008;
  localparam logic [15:0] IDX_POWER_CTL = 16'h0009;
  localparam logic [15:0] IDX_CFG_ONE   = 16'h8007;
  localparam logic [15:0] IDX_CFG_TWO   = 16'h8008;

  localparam int unsigned OVF_BIT = 7;
  localparam int unsigned UNF_BIT = 6;
  localparam int unsigned CFG2_STACK_RESET_BIT = 9;
  localparam logic [13:0] CFG_RESET = 14'h3FFF;

  localparam logic [15:0] TRAD_LAST = 16'h0FFF;
  localparam logic [15:0] LIN_BASE  = 16'h2000;
  localparam logic [15:0] LIN_LAST  = 16'h29AF;
  localparam logic [11:0] LIN_BLOCK = 12'h050;
  localparam logic [6:0]  GPR_OFS   = 7'h20;
  localparam int unsigned FLASH_BIT = 15;

  typedef enum logic [3:0] {
    OP_NONE, OP_STEP, OP_PCL_WRITE, OP_CALL, OP_INDIRECT_CALL,
    OP_BRW, OP_BRA, OP_RETURN, OP_IRQ
  } core_op_t;

  typedef struct packed {
    core_op_t    op;
    logic [10:0] operand;
    logic [7:0]  wreg;
  } core_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       sel;
    logic       write;
    logic [7:0] wdata;
  } ind_req_t;

  typedef enum logic [1:0] {REGION_NONE, REGION_DATA, REGION_FLASH} region_t;

  typedef struct packed {
    logic        valid;
    region_t     region;
    logic [14:0] addr;
    logic        write;
    logic [7:0]  wdata;
  } mem_req_t;

  typedef struct packed {
    logic       valid;
    logic       extra_cycle;
    logic [7:0] data;
  } ind_rsp_t;

endpackage : pc_stack_pkg

// File: verilog/pc_stack_unit.sv
// program counter, return stack and indirect pointer resolution
`timescale 1ns/1ps
module pc_stack_unit #(
  parameter logic [13:0] CFG1_VALUE = pc_stack_pkg::CFG_RESET,
  parameter logic [13:0] CFG2_VALUE = pc_stack_pkg::CFG_RESET
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [17:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire pc_stack_pkg::core_cmd_t core_cmd,
  output logic                         core_ready,
  input  wire pc_stack_pkg::ind_req_t  ind_req,
  output pc_stack_pkg::mem_req_t       mem_req,
  input  wire logic [13:0]             mem_rdata,
  output pc_stack_pkg::ind_rsp_t       ind_rsp,
  output logic [14:0]                  pc,
  output logic                         stack_fault_reset
);
  import pc_stack_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_mapped(input logic [15:0] i);
    return (i <= IDX_POWER_CTL) || (i == IDX_CFG_ONE) || (i == IDX_CFG_TWO);
  endfunction : is_mapped

  function automatic logic is_self(input logic [14:0] a);
    return a[6:1] == 6'h00;
  endfunction : is_self

  function automatic logic [14:0] linear_to_data(input logic [15:0] a);
    logic [11:0] off;
    logic [11:0] bank;
    logic [11:0] slot;
    off  = 12'(a - LIN_BASE);
    bank = off / LIN_BLOCK;
    slot = off % LIN_BLOCK;
    return {3'b000, bank[4:0], 7'(slot[6:0] + GPR_OFS)};
  endfunction : linear_to_data

  //////////////////////////////////////////////////////////////////////////////
  // state

  logic [14:0] pc_r;
  logic [6:0]  latch_r;
  logic [4:0]  sp_r;
  logic [14:0] stack_r [STK_DEPTH];
  logic [7:0]  ptr_lo_r [2];
  logic [7:0]  ptr_hi_r [2];
  logic        ovf_r;
  logic        unf_r;
  logic        fault_r;
  logic [31:0] prdata_r;
  mem_req_t    mem_req_r;
  ind_rsp_t    rsp_r;
  logic        pend_r;
  logic        pend_zero_r;
  logic        pend_flash_r;

  //////////////////////////////////////////////////////////////////////////////
  // apb slave

  logic [15:0] idx;
  logic        wr_en;
  logic        wr_pcl;
  logic        wr_sp;
  logic        wr_top_stack_low_byte;
  logic        wr_top_stack_high_byte;
  logic [7:0]  wbyte;
  logic [31:0] rd_val;
  logic        stack_option;

  assign idx    = paddr[17:2];
  assign wbyte  = pwdata[7:0];
  assign wr_en  = psel & penable & pwrite & pstrb[0] & is_mapped(idx);
  assign wr_pcl = wr_en && (idx == IDX_PC_LOW);
  assign wr_sp  = wr_en && (idx == IDX_STACK_PTR);
  assign wr_top_stack_low_byte = wr_en && (idx == IDX_TOS_LOW);
  assign wr_top_stack_high_byte = wr_en && (idx == IDX_TOS_HIGH);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(idx);
  assign prdata  = prdata_r;

  // (RQ23) option from second word
  assign stack_option = CFG2_VALUE[CFG2_STACK_RESET_BIT];

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (idx)
      IDX_PC_LOW:    rd_val[7:0] = pc_r[7:0];
      IDX_PC_LATCH:  rd_val[6:0] = latch_r;
      IDX_STACK_PTR: rd_val[4:0] = sp_r;
      // (RQ11) top of stack view
      IDX_TOS_LOW:   rd_val[7:0] = stack_r[sp_r[3:0]][7:0];
      IDX_TOS_HIGH:  rd_val[6:0] = stack_r[sp_r[3:0]][14:8];
      IDX_PTR0_LOW:  rd_val[7:0] = ptr_lo_r[0];
      IDX_PTR0_HIGH: rd_val[7:0] = ptr_hi_r[0];
      IDX_PTR1_LOW:  rd_val[7:0] = ptr_lo_r[1];
      IDX_PTR1_HIGH: rd_val[7:0] = ptr_hi_r[1];
      IDX_POWER_CTL:
      begin
        rd_val[OVF_BIT] = ovf_r;
        rd_val[UNF_BIT] = unf_r;
      end
      // (RQ22) configuration words
      IDX_CFG_ONE:   rd_val[13:0] = CFG1_VALUE;
      IDX_CFG_TWO:   rd_val[13:0] = CFG2_VALUE;
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_r <= rd_val;
  end

  //////////////////////////////////////////////////////////////////////////////
  // core command decode

  logic        push;
  logic        pop;
  logic [4:0]  sp_inc;
  logic [4:0]  sp_dec;
  logic        ovf_ev;
  logic        unf_ev;
  logic        fault_now;
  logic [14:0] push_val;

  assign core_ready = !(wr_pcl | wr_sp | wr_top_stack_low_byte | wr_top_stack_high_byte);
  assign push = core_ready && (core_cmd.op == OP_CALL ||
                core_cmd.op == OP_INDIRECT_CALL || core_cmd.op == OP_IRQ);
  assign pop  = core_ready && (core_cmd.op == OP_RETURN);
  assign sp_inc = 5'(sp_r + 5'h01);
  assign sp_dec = 5'(sp_r - 5'h01);
  // (RQ12) fifth bit exposes faults
  assign ovf_ev = push && sp_inc[4] && (sp_r != SP_EMPTY);
  assign unf_ev = pop && (sp_r == SP_EMPTY);
  assign fault_now = stack_option && (ovf_ev || unf_ev);
  assign push_val = (core_cmd.op == OP_IRQ) ? pc_r : 15'(pc_r + 15'h0001);

  //////////////////////////////////////////////////////////////////////////////
  // program counter

  always_ff @(posedge pclk or negedge presetn)
  begin
    // (RQ1) cleared by every reset
    if (!presetn)
      pc_r <= 15'h0000;
    else if (fault_now)
      pc_r <= 15'h0000;
    // (RQ2) full counter reload
    else if (wr_pcl)
      pc_r <= {latch_r, wbyte};
    else
    begin
      unique case (core_cmd.op)
        OP_NONE:      pc_r <= pc_r;
        // (RQ24) plain step
        OP_STEP:      pc_r <= 15'(pc_r + 15'h0001);
        OP_PCL_WRITE: pc_r <= {latch_r, core_cmd.wreg};
        // (RQ3) direct call target
        OP_CALL:      pc_r <= {latch_r[6:3], core_cmd.operand};
        // (RQ4) indirect call target
        OP_INDIRECT_CALL:     pc_r <= {latch_r, core_cmd.wreg};
        // (RQ5) unsigned register branch
        OP_BRW:       pc_r <= 15'(pc_r + 15'h0001 + {7'h00, core_cmd.wreg});
        // (RQ6) signed operand branch
        OP_BRA:       pc_r <= 15'(pc_r + 15'h0001 +
                          {{6{core_cmd.operand[8]}}, core_cmd.operand[8:0]});
        // (RQ13) pop reads first
        OP_RETURN:    pc_r <= stack_r[sp_r[3:0]];
        OP_IRQ:       pc_r <= IRQ_VECTOR;
        default:      pc_r <= pc_r;
      endcase
    end
  end

  assign pc = pc_r;

  // (RQ8) latch only changed by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_r <= 7'h00;
    else if (wr_en && idx == IDX_PC_LATCH)
      latch_r <= wbyte[6:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // return stack

  always_ff @(posedge pclk or negedge presetn)
  begin
    // (RQ14) empty pointer value
    if (!presetn)
      sp_r <= SP_EMPTY;
    else if (fault_now)
      sp_r <= SP_EMPTY;
    else if (wr_sp)
      sp_r <= wbyte[4:0];
    // (RQ9) pointer wraps through low bits
    else if (push)
      sp_r <= sp_inc;
    else if (pop)
      sp_r <= sp_dec;
  end

  // (RQ7) sixteen entries of fifteen bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < STK_DEPTH; i++)
        stack_r[i] <= 15'h0000;
    end
    else if (wr_top_stack_low_byte)
      stack_r[sp_r[3:0]][7:0] <= wbyte;
    else if (wr_top_stack_high_byte)
      stack_r[sp_r[3:0]][14:8] <= wbyte[6:0];
    // (RQ13) push writes after increment
    else if (push && !fault_now)
      stack_r[sp_inc[3:0]] <= push_val;
  end

  // (RQ10) flags, set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end
    else
    begin
      ovf_r <= ovf_ev | (ovf_r &
               ~(wr_en && idx == IDX_POWER_CTL && !pwdata[OVF_BIT]));
      unf_r <= unf_ev | (unf_r &
               ~(wr_en && idx == IDX_POWER_CTL && !pwdata[UNF_BIT]));
    end
  end

  // (RQ15) device reset request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_r <= 1'b0;
    else
      fault_r <= fault_now;
  end

  assign stack_fault_reset = fault_r;

  //////////////////////////////////////////////////////////////////////////////
  // indirect pointers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_lo_r[0] <= 8'h00;
      ptr_lo_r[1] <= 8'h00;
      ptr_hi_r[0] <= 8'h00;
      ptr_hi_r[1] <= 8'h00;
    end
    else if (wr_en)
    begin
      if (idx == IDX_PTR0_LOW)
        ptr_lo_r[0] <= wbyte;
      if (idx == IDX_PTR0_HIGH)
        ptr_hi_r[0] <= wbyte;
      if (idx == IDX_PTR1_LOW)
        ptr_lo_r[1] <= wbyte;
      if (idx == IDX_PTR1_HIGH)
        ptr_hi_r[1] <= wbyte;
    end
  end

  logic [15:0] ind_addr;
  mem_req_t    req_nxt;
  logic        zero_nxt;
  logic        self_hit;

  // (RQ16) pointer pair forms the address
  assign ind_addr = {ptr_hi_r[ind_req.sel], ptr_lo_r[ind_req.sel]};

  always_comb
  begin
    req_nxt  = '0;
    zero_nxt = 1'b1;
    self_hit = 1'b0;
    req_nxt.write = ind_req.write;
    req_nxt.wdata = ind_req.wdata;
    // (RQ21) program flash, read only
    if (ind_addr[FLASH_BIT])
    begin
      req_nxt.region = REGION_FLASH;
      req_nxt.addr   = ind_addr[14:0];
      req_nxt.write  = 1'b0;
      req_nxt.valid  = ind_req.valid && !ind_req.write;
      zero_nxt       = ind_req.write;
    end
    // (RQ18) traditional data region
    else if (ind_addr <= TRAD_LAST)
    begin
      self_hit       = is_self({3'b000, ind_addr[11:0]});
      req_nxt.region = REGION_DATA;
      req_nxt.addr   = {3'b000, ind_addr[11:0]};
      req_nxt.valid  = ind_req.valid && !self_hit;
      zero_nxt       = self_hit;
    end
    // (RQ19) linear view of bank blocks
    else if (ind_addr >= LIN_BASE && ind_addr <= LIN_LAST)
    begin
      req_nxt.region = REGION_DATA;
      req_nxt.addr   = linear_to_data(ind_addr);
      req_nxt.valid  = ind_req.valid;
      zero_nxt       = 1'b0;
    end
    // (RQ20) unmapped reads zero
    else
    begin
      req_nxt.region = REGION_NONE;
      req_nxt.valid  = 1'b0;
      zero_nxt       = 1'b1;
    end
    if (!req_nxt.valid)
      req_nxt.region = REGION_NONE;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_req_r    <= '0;
      pend_r       <= 1'b0;
      pend_zero_r  <= 1'b0;
      pend_flash_r <= 1'b0;
    end
    else
    begin
      mem_req_r    <= req_nxt;
      pend_r       <= ind_req.valid;
      pend_zero_r  <= zero_nxt;
      pend_flash_r <= ind_addr[FLASH_BIT];
    end
  end

  // (RQ17) self reference returns zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsp_r <= '0;
    else
    begin
      rsp_r.valid       <= pend_r;
      rsp_r.extra_cycle <= pend_r && pend_flash_r;
      rsp_r.data        <= pend_zero_r ? 8'h00 : mem_rdata[7:0];
    end
  end

  assign mem_req = mem_req_r;
  assign ind_rsp = rsp_r;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_self_req;
    ind_req.valid && self_hit;
  endsequence

  sequence s_zero_answer;
    !mem_req.valid ##1 (ind_rsp.valid && ind_rsp.data == 8'h00);
  endsequence

  AST_PCL_WRITE: assert property ( // RQ2
    (wr_pcl && !fault_now) |=> pc == {$past(latch_r), $past(wbyte)})
    else $error("low byte write did not reload counter");

  AST_CALL: assert property ( // RQ3
    (core_ready && core_cmd.op == OP_CALL && !fault_now) |=>
    (pc == {$past(latch_r[6:3]), $past(core_cmd.operand)}) &&
    (stack_r[sp_r[3:0]] == 15'($past(pc_r) + 15'h0001)))
    else $error("call target or return address wrong");

  AST_INDIRECT_CALL: assert property ( // RQ4
    (core_ready && core_cmd.op == OP_INDIRECT_CALL && !fault_now) |=>
    pc == {$past(latch_r), $past(core_cmd.wreg)})
    else $error("indirect call target wrong");

  AST_BRW: assert property ( // RQ5
    (core_ready && core_cmd.op == OP_BRW) |=>
    pc == 15'($past(pc_r) + 15'h0001 + {7'h00, $past(core_cmd.wreg)}))
    else $error("register branch target wrong");

  AST_STEP: assert property ( // RQ24
    (core_ready && core_cmd.op == OP_STEP) ##1
    (core_ready && core_cmd.op == OP_STEP) |=>
    pc == 15'($past(pc_r, 2) + 15'h0002))
    else $error("counter did not step by one");

  AST_FIRST_PUSH: assert property ( // RQ14
    (sp_r == SP_EMPTY && push && !fault_now) |=> sp_r == 5'h00)
    else $error("first push did not give pointer zero");

  AST_LAST_POP: assert property ( // RQ14
    (sp_r == 5'h00 && pop) |=> sp_r == SP_EMPTY)
    else $error("pop from first entry did not give empty pointer");

  AST_WRAP: assert property ( // RQ9
    (!stack_option && push && sp_r == 5'h0F) |=>
    (sp_r == 5'h10) && (stack_r[0] == $past(push_val)))
    else $error("stack did not wrap over first entry");

  AST_OVF_FLAG: assert property ( // RQ10
    ovf_ev |=> ovf_r [*2] or (ovf_r ##1 1'b1))
    else $error("overflow flag not set");

  AST_FAULT: assert property ( // RQ15
    (stack_option && unf_ev) |=>
    stack_fault_reset && unf_r && sp_r == SP_EMPTY && pc == 15'h0000 ##1
    !stack_fault_reset)
    else $error("stack fault reset sequence wrong");

  AST_LATCH_KEPT: assert property ( // RQ8
    (push || pop) && !wr_en |=> $stable(latch_r))
    else $error("high latch changed by push or pop");

  AST_SELF: assert property ( // RQ17
    s_self_req |=> s_zero_answer)
    else $error("self reference did not read zero");

endmodule : pc_stack_unit

// File: tb/core_mem_model.sv
// data and flash memory seen by the indirect pointer path
`timescale 1ns/1ps
module core_mem_model (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire pc_stack_pkg::mem_req_t mem_req,
  output logic [13:0]                 mem_rdata
);
  import pc_stack_pkg::*;

  logic [13:0] churn_r;

  ////////////////////////////////////////////////////////////////////////
  // content derived from address, flash distinct
  function automatic logic [13:0] fold(input region_t r,
                                       input logic [14:0] a);
    return {a[13:8], a[7:0] ^ a[14:7] ^ ((r == REGION_FLASH) ? 8'hA5 : 8'h00)};
  endfunction : fold

  ////////////////////////////////////////////////////////////////////////
  // bus never holds a stale value when idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      churn_r <= 14'h1555;
    else
      churn_r <= churn_r + 14'h1357;
  end

  assign mem_rdata = mem_req.valid ? fold(mem_req.region, mem_req.addr)
                                   : churn_r;
endmodule : core_mem_model

// File: tb/test_program_counter_stack_indirect.sv
// self-checking bench of the program flow and indirect unit
`timescale 1ns/1ps
module test_program_counter_stack_indirect;
  import pc_stack_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, core_ready, special_function_reg, sfr_w;
  core_cmd_t   core_cmd;
  ind_req_t    ind_req;
  mem_req_t    mem_req;
  ind_rsp_t    ind_rsp;
  logic [13:0] mem_rdata;
  logic [14:0] pc, pc_w, ret, ret2, e;
  logic [6:0]  lat;
  logic [7:0]  w;
  logic [10:0] o;
  logic [15:0] n;
  logic [32:0] nt;
  logic [8:0]  ni;
  logic [32:0] q_rd[$];
  logic [8:0]  q_ind[$];
  int          n_errors = 0;
  int          n_checks = 0;

  pc_stack_unit dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_cmd(core_cmd), .core_ready(core_ready), .ind_req(ind_req),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .ind_rsp(ind_rsp), .pc(pc),
    .stack_fault_reset(special_function_reg));

  // wrapping stack variant
  pc_stack_unit #(.CFG2_VALUE(14'h3DFF)) dut_wrap (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(),
    .pready(), .pslverr(), .core_cmd(core_cmd), .core_ready(),
    .ind_req(ind_req), .mem_req(), .mem_rdata(mem_rdata), .ind_rsp(),
    .pc(pc_w), .stack_fault_reset(sfr_w));

  core_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_rdata(mem_rdata));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic chk_pc(input logic [14:0] x);
    chk("pc", {17'h0, x}, {17'h0, pc});
  endtask : chk_pc

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] idx, input logic [32:0] x);
    q_rd.push_back(x);
    apb(1'b0, idx, 8'h00);
  endtask : rd

  task automatic op(input core_op_t c, input logic [10:0] a,
                    input logic [7:0] v);
    @(posedge pclk);
    core_cmd <= '{c, a, v};
    @(posedge pclk);
    core_cmd <= '{OP_NONE, 11'h000, 8'h00};
    @(negedge pclk);
  endtask : op

  task automatic ind(input logic s, input logic [15:0] p,
                     input logic [8:0] x);
    apb(1'b1, s ? IDX_PTR1_LOW : IDX_PTR0_LOW, p[7:0]);
    apb(1'b1, s ? IDX_PTR1_HIGH : IDX_PTR0_HIGH, p[15:8]);
    q_ind.push_back(x);
    @(posedge pclk);
    ind_req <= '{1'b1, s, 1'b0, 8'h00};
    @(posedge pclk);
    ind_req <= '{1'b0, 1'b0, 1'b0, 8'h00};
    repeat (2) @(posedge pclk);
  endtask : ind

  task automatic ind_wr(input logic s, input logic [8:0] x);
    q_ind.push_back(x);
    @(posedge pclk);
    ind_req <= '{1'b1, s, 1'b1, 8'h5A};
    @(posedge pclk);
    ind_req <= '{1'b0, 1'b0, 1'b0, 8'h00};
    @(negedge pclk);
    chk("mem_req", 32'h0, {31'h0, mem_req.valid});
    repeat (2) @(posedge pclk);
  endtask : ind_wr

  ////////////////////////////////////////////////////////////////////////
  // result watcher against the noted expectations
  always @(posedge pclk)
  begin
    if (presetn && psel && penable && pready && !pwrite && q_rd.size() > 0)
    begin
      nt = q_rd.pop_front();
      chk("prdata", nt[31:0], prdata);
      chk("pslverr", {31'h0, nt[32]}, {31'h0, pslverr});
    end
    if (ind_rsp.valid === 1'b1)
    begin
      ni = (q_ind.size() > 0) ? q_ind.pop_front() : 9'h1FF;
      chk("ind_data", {24'h0, ni[7:0]}, {24'h0, ind_rsp.data});
      chk("ind_extra", {31'h0, ni[8]}, {31'h0, ind_rsp.extra_cycle});
    end
  end

  initial
  begin
    repeat (8000) @(posedge pclk);
    n_errors++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    core_cmd = '{OP_NONE, 11'h000, 8'h00};
    ind_req = '{1'b0, 1'b0, 1'b0, 8'h00};
    void'($urandom(39093));
    do_reset();
    chk_pc(15'h0000);
    rd(IDX_STACK_PTR, 33'h1F);
    rd(IDX_POWER_CTL, 33'h0);
    rd(IDX_CFG_TWO, {19'h0, CFG_RESET});
    rd(16'h0100, {1'b1, 32'h0});
    n = 16'($urandom_range(8, 1));
    repeat (n) op(OP_STEP, 11'h000, 8'h00);
    chk_pc(15'(n));
    lat = 7'($urandom);
    w = 8'($urandom);
    apb(1'b1, IDX_PC_LATCH, {1'b0, lat});
    apb(1'b1, IDX_PC_LOW, w);
    op(OP_NONE, 11'h000, 8'h00);
    chk_pc({lat, w});
    w = 8'($urandom);
    op(OP_PCL_WRITE, 11'h000, w);
    chk_pc({lat, w});
    o = 11'($urandom);
    ret = {lat, w} + 15'h1;
    op(OP_CALL, o, 8'h00);
    chk_pc({lat[6:3], o});
    rd(IDX_STACK_PTR, 33'h00);
    rd(IDX_TOS_LOW, {25'h0, ret[7:0]});
    rd(IDX_TOS_HIGH, {26'h0, ret[14:8]});
    rd(IDX_PC_LATCH, {26'h0, lat});
    ret2 = {lat[6:3], o} + 15'h1;
    op(OP_INDIRECT_CALL, 11'h000, w);
    chk_pc({lat, w});
    op(OP_BRW, 11'h000, 8'hFF);
    chk_pc({lat, w} + 15'h100);
    o = 11'($urandom) | 11'h100;
    e = {lat, w} + 15'h101 + {{6{o[8]}}, o[8:0]};
    op(OP_BRA, o, 8'h00);
    chk_pc(e);
    op(OP_RETURN, 11'h000, 8'h00);
    chk_pc(ret2);
    op(OP_RETURN, 11'h000, 8'h00);
    chk_pc(ret);
    rd(IDX_STACK_PTR, 33'h1F);
    op(OP_IRQ, 11'h000, 8'h00);
    chk_pc(IRQ_VECTOR);
    op(OP_RETURN, 11'h000, 8'h00);
    chk_pc(ret);
    apb(1'b1, IDX_STACK_PTR, 8'h05);
    apb(1'b1, IDX_TOS_LOW, w);
    apb(1'b1, IDX_TOS_HIGH, {1'b0, lat});
    rd(IDX_TOS_LOW, {25'h0, w});
    op(OP_RETURN, 11'h000, 8'h00);
    chk_pc({lat, w});
    rd(IDX_STACK_PTR, 33'h04);
    n = 16'($urandom_range(16'h09AF, 0));
    ind(1'b0, 16'h0123, {1'b0, 8'(mem_u.fold(REGION_DATA, 15'h0123))});
    e = 15'((n / 80) * 128 + 32 + n % 80);
    ind(1'b1, LIN_BASE + n, {1'b0, 8'(mem_u.fold(REGION_DATA, e))});
    ind(1'b0, 16'h0081, 9'h000);
    ind(1'b1, 16'h1500, 9'h000);
    ind(1'b0, 16'h29B0, 9'h000);
    e = n[14:0] | 15'h4000;
    ind(1'b1, {1'b1, e}, {1'b1, 8'(mem_u.fold(REGION_FLASH, e))});
    ind_wr(1'b1, 9'h100);
    apb(1'b1, IDX_PTR0_HIGH, 8'h00);
    apb(1'b1, IDX_PTR0_LOW, 8'h81);
    ind_wr(1'b0, 9'h000);
    do_reset();
    for (int k = 1; k <= 17; k++)
      op(OP_CALL, 11'(k * 8), 8'h00);
    chk("sfr", 32'h1, {31'h0, special_function_reg});
    chk("sfr_w", 32'h0, {31'h0, sfr_w});
    chk_pc(15'h0000);
    chk("pc_w", 32'h88, {17'h0, pc_w});
    rd(IDX_POWER_CTL, 33'h80);
    apb(1'b1, IDX_POWER_CTL, 8'h00);
    op(OP_RETURN, 11'h000, 8'h00);
    chk("pc_w", 32'h81, {17'h0, pc_w});
    chk("sfr", 32'h1, {31'h0, special_function_reg});
    rd(IDX_POWER_CTL, 33'h40);
    op(OP_RETURN, 11'h000, 8'h00);
    chk("pc_w", 32'h79, {17'h0, pc_w});
    stop_test();
  end
endmodule : test_program_counter_stack_indirect
